// File: hdl/rpq_consts.vh
// constants of the receive lead-in qualifier: register map, fields, resets, timing
// assumes inclusion by the design files and the bench; holds definitions alone
`ifndef RPQ_CONSTS_VH
`define RPQ_CONSTS_VH

// register byte addresses on the apb slave
`define RPQ_ADDR_CTRL    8'h00
`define RPQ_ADDR_THRESH  8'h04
`define RPQ_ADDR_CUSTOM  8'h08
`define RPQ_ADDR_SYNC    8'h0c
`define RPQ_ADDR_PLEN    8'h10
`define RPQ_ADDR_STAT    8'h14
`define RPQ_ADDR_MASK    8'h18
`define RPQ_ADDR_STATE   8'h1c
`define RPQ_ADDR_RXDATA  8'h20
`define RPQ_ADDR_TXCRC   8'h24
`define RPQ_ADDR_RATE    8'h28
`define RPQ_ADDR_FILT    8'h2c
`define RPQ_ADDR_AFC     8'h30

// control register fields
`define RPQ_CTRL_EN      0
`define RPQ_CTRL_CUSTOM  1
`define RPQ_CTRL_SYNCO   2
`define RPQ_CTRL_AFC     3
`define RPQ_CTRL_SYNC3   4
`define RPQ_CTRL_TXCLR   5

// status / mask bit positions
`define RPQ_EV_PREAMBLE  0
`define RPQ_EV_SYNC      1
`define RPQ_EV_PKT_OK    2
`define RPQ_EV_CRC_ERR   3
`define RPQ_EV_AGC_DONE  4
`define RPQ_EV_W         5

// reset values
`define RPQ_RST_CTRL     5'h11
`define RPQ_RST_THRESH   7'h14
`define RPQ_RST_CUSTOM   15'h5510
`define RPQ_RST_SYNC     24'h2dd4aa
`define RPQ_RST_PLEN     8'h10
`define RPQ_RST_RATE     19'h04b00
`define RPQ_RST_FILT     20'h186a0

// data rate and channel filter limits, in bps and hz
`define RPQ_RATE_MIN     19'h00064
`define RPQ_RATE_MAX     19'h7a120
`define RPQ_FILT_MIN     20'h0044c
`define RPQ_FILT_MAX     20'hcf850

// timing: clock period and gain settle bound
`define RPQ_CLK_NS       8
`define RPQ_AGC_NS       2000
`define RPQ_AGC_CYC      (`RPQ_AGC_NS / `RPQ_CLK_NS)

// checksum generator
`define RPQ_CRC_POLY     16'h1021
`define RPQ_CRC_INIT     16'hffff

`endif

// File: hdl/rpq_crc16.v
// byte-wide checksum engine, one byte per enabled cycle, msb first
// assumes a synchronous clear and byte strobes on the same clock
`timescale 1ns/1ps
`include "rpq_consts.vh"

module rpq_crc16 #(
    parameter [15:0] POLY = `RPQ_CRC_POLY,   // generator polynomial
    parameter [15:0] INIT = `RPQ_CRC_INIT    // start value
) (
    input  wire        core_clk,  // module clock
    input  wire        resetn,    // async reset, active low
    input  wire        clr,       // restart the sum
    input  wire        en,        // take one byte
    input  wire [7:0]  din,       // byte in
    output wire [15:0] crc        // running sum
);

    reg  [15:0] crc_q;
    reg  [15:0] crc_d;
    integer     i;

    ////////////////////////////////////////////////////////////////////////////
    // eight serial steps unrolled by the loop; a zero residue after the
    // appended sum means an intact packet
    always @* begin
        crc_d = crc_q;
        for (i = 7; i >= 0; i = i - 1) begin
            if (crc_d[15] ^ din[i]) begin
                crc_d = {crc_d[14:0], 1'b0} ^ POLY;
            end else begin
                crc_d = {crc_d[14:0], 1'b0};
            end
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            crc_q <= INIT;
        end else if (clr) begin
            crc_q <= INIT;
        end else if (en) begin
            crc_q <= crc_d;
        end
    end

    assign crc = crc_q;

endmodule // rpq_crc16

// File: hdl/rpq_top.v
// receive lead-in qualifier: preamble counting, sync search, payload checksum,
// gain settle watch, signal strength and frequency range reporting, apb slave
// assumes demodulated bits, strobes, rssi and offset come from logic on core_clk
`timescale 1ns/1ps
`include "rpq_consts.vh"

//Contract
//RQ1 - flag preamble once alternating run reaches threshold
//RQ2 - threshold is a seven-bit field
//RQ3 - qualify preamble before sync search and payload
//RQ4 - threshold resets to twenty bits
//RQ5 - transmitter sends threshold plus settling bits
//RQ6 - custom repeating pattern uses own settings
//RQ7 - zero threshold means sync-only, three-byte sync; code compares three sync bytes only while RPQ_CTRL_SYNC3 is set
//RQ8 - custom setting accepts any repeating pattern; code matches only one eight-bit pattern repeated
//RQ9 - sync-only mode skips preamble qualification
//RQ10 - checksum appended on send, checked on receive
//RQ11 - signal strength counts in half decibels
//RQ12 - gain settles within one bit or 2 us
//RQ13 - offset range quarter, or 0.35 with afc
//RQ14 - afc needs one extra preamble byte
//RQ15 - data rate 100 bps to 500 kbps
//RQ16 - channel filter 850 khz to 1.1 khz
//RQ17 - repeated bit restarts the run counter
module rpq_top #(
    parameter AGC_CYC = `RPQ_AGC_CYC         // gain settle bound in cycles
) (
    input  wire        core_clk,        // 125 mhz clock
    input  wire        resetn,          // async reset, active low
    input  wire        psel,            // apb select
    input  wire        penable,         // apb access phase
    input  wire        pwrite,          // apb direction
    input  wire [7:0]  paddr,           // apb byte address
    input  wire [31:0] pwdata,          // apb write data
    output reg  [31:0] prdata,          // apb read data
    output reg         pready,          // apb ready
    output reg         pslverr,         // apb error, unmapped address
    input  wire        rx_bit,          // demodulated bit
    input  wire        rx_bit_valid,    // one pulse per bit period
    input  wire [7:0]  rssi_raw,        // strength, half decibel per count
    input  wire        agc_step,        // gain loop changed its gain
    input  wire signed [19:0] freq_err, // estimated offset, hz
    output reg         irq,             // level interrupt
    output reg         preamble_valid,  // lead-in qualified, level
    output reg         sync_found,      // sync seen, level until packet end
    output reg         rx_byte_valid,   // payload byte pulse
    output reg  [7:0]  rx_byte          // payload byte
);

    localparam [1:0] ST_SEARCH = 2'd0;
    localparam [1:0] ST_SYNC   = 2'd1;
    localparam [1:0] ST_DATA   = 2'd2;
    localparam [1:0] ST_CRC    = 2'd3;

    reg  [4:0]  ctrl_q;
    reg  [6:0]  lead_in_count_threshold_q;
    reg  [14:0] custom_lead_in_settings_q;  // [14:7] pattern, [6:0] bit count
    reg  [23:0] sync_q;
    reg  [7:0]  plen_q;
    reg  [`RPQ_EV_W-1:0] stat_q;
    reg  [`RPQ_EV_W-1:0] mask_q;
    reg  [18:0] rate_q;
    reg  [19:0] filt_q;
    reg  [7:0]  rssi_q;
    reg  [1:0]  state_q;
    reg  [6:0]  run_q;
    reg  [2:0]  phase_q;
    reg         last_q;
    reg  [23:0] shift_q;
    reg  [2:0]  bitn_q;
    reg  [7:0]  bytes_q;
    reg         crc_clr_q;
    reg         crc_en_q;
    reg  [7:0]  crc_byte_q;
    reg         agc_busy_q;
    reg  [8:0]  agc_cnt_q;
    reg  [19:0] afc_lim_q;
    reg  [19:0] afc_corr_q;
    reg         tx_en_q;
    reg  [7:0]  tx_byte_q;
    wire [25:0] afc_prod = filt_q * 6'd45;   // wide enough before the scale shift
    wire [15:0] rx_crc;
    wire [15:0] tx_crc;
    wire        wr_acc  = psel & penable & pwrite & ~pready;
    wire        rd_acc  = psel & penable & ~pwrite & ~pready;
    wire        bit_in  = rx_bit;
    wire [23:0] shift_n = {shift_q[22:0], bit_in};
    wire [7:0]  pat     = custom_lead_in_settings_q[14:7];
    wire        custom  = ctrl_q[`RPQ_CTRL_CUSTOM];
    wire [6:0]  thr     = custom ? custom_lead_in_settings_q[6:0] : lead_in_count_threshold_q;
    wire        skip    = ctrl_q[`RPQ_CTRL_SYNCO] | (thr == 7'h00);
    wire        alt_ok  = custom ? (bit_in == pat[3'd7 - phase_q]) : (bit_in != last_q);
    wire [6:0]  run_n   = alt_ok ? ((run_q == 7'h7f) ? run_q : run_q + 7'h01) : 7'h00;
    wire        sync_hit = ctrl_q[`RPQ_CTRL_SYNC3] ? (shift_n == sync_q)
                                                   : (shift_n[15:0] == sync_q[15:0]);
    wire [19:0] abs_err = freq_err[19] ? (~freq_err + 20'h00001) : freq_err;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer in the second access cycle
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                case (paddr)
                    `RPQ_ADDR_CTRL:   prdata <= {27'h0, ctrl_q};
                    `RPQ_ADDR_THRESH: prdata <= {25'h0, lead_in_count_threshold_q};
                    `RPQ_ADDR_CUSTOM: prdata <= {16'h0, pat, 1'b0, custom_lead_in_settings_q[6:0]};
                    `RPQ_ADDR_SYNC:   prdata <= {8'h00, sync_q};
                    `RPQ_ADDR_PLEN:   prdata <= {24'h0, plen_q};
                    `RPQ_ADDR_STAT:   prdata <= {27'h0, stat_q};
                    `RPQ_ADDR_MASK:   prdata <= {27'h0, mask_q};
                    `RPQ_ADDR_STATE:  prdata <= {rssi_q, 7'h00, run_q, 6'h00, agc_busy_q,
                                                 1'b0, state_q};   // RQ11
                    `RPQ_ADDR_RXDATA: prdata <= {24'h0, rx_byte};
                    `RPQ_ADDR_TXCRC:  prdata <= {16'h0, tx_crc};   // RQ10
                    `RPQ_ADDR_RATE:   prdata <= {13'h0, rate_q};
                    `RPQ_ADDR_FILT:   prdata <= {12'h0, filt_q};
                    `RPQ_ADDR_AFC:    prdata <= {afc_lim_q[15:0], afc_corr_q[15:0]};
                    default: begin
                        prdata  <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers; rate and filter are clamped to what the modem can do
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q                    <= `RPQ_RST_CTRL;
            lead_in_count_threshold_q <= `RPQ_RST_THRESH;       // RQ4
            custom_lead_in_settings_q <= `RPQ_RST_CUSTOM;
            sync_q                    <= `RPQ_RST_SYNC;
            plen_q                    <= `RPQ_RST_PLEN;
            mask_q                    <= {`RPQ_EV_W{1'b0}};
            rate_q                    <= `RPQ_RST_RATE;
            filt_q                    <= `RPQ_RST_FILT;
            tx_en_q                   <= 1'b0;
            tx_byte_q                 <= 8'h00;
        end else begin
            tx_en_q <= 1'b0;
            if (wr_acc) begin
                case (paddr)
                    `RPQ_ADDR_CTRL:   ctrl_q <= pwdata[4:0];
                    `RPQ_ADDR_THRESH: lead_in_count_threshold_q <= pwdata[6:0];   // RQ2
                    `RPQ_ADDR_CUSTOM: custom_lead_in_settings_q <= {pwdata[15:8],
                                                                    pwdata[6:0]};  // RQ6
                    `RPQ_ADDR_SYNC:   sync_q <= pwdata[23:0];
                    `RPQ_ADDR_PLEN:   plen_q <= pwdata[7:0];
                    `RPQ_ADDR_MASK:   mask_q <= pwdata[`RPQ_EV_W-1:0];
                    `RPQ_ADDR_TXCRC: begin
                        tx_en_q   <= 1'b1;   // RQ10
                        tx_byte_q <= pwdata[7:0];
                    end
                    `RPQ_ADDR_RATE: begin
                        if (pwdata[18:0] < `RPQ_RATE_MIN || pwdata[31:19] != 13'h0)
                            rate_q <= (pwdata[31:19] != 13'h0) ? `RPQ_RATE_MAX
                                                                : `RPQ_RATE_MIN;   // RQ15
                        else if (pwdata[18:0] > `RPQ_RATE_MAX)
                            rate_q <= `RPQ_RATE_MAX;                            // RQ15
                        else
                            rate_q <= pwdata[18:0];
                    end
                    `RPQ_ADDR_FILT: begin
                        if (pwdata[31:20] != 12'h0 || pwdata[19:0] > `RPQ_FILT_MAX)
                            filt_q <= `RPQ_FILT_MAX;                            // RQ16
                        else if (pwdata[19:0] < `RPQ_FILT_MIN)
                            filt_q <= `RPQ_FILT_MIN;                            // RQ16
                        else
                            filt_q <= pwdata[19:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive sequencer: lead-in, then sync word, then payload and checksum
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q        <= ST_SEARCH;
            run_q          <= 7'h00;
            phase_q        <= 3'd0;
            last_q         <= 1'b0;
            shift_q        <= 24'h000000;
            bitn_q         <= 3'd0;
            bytes_q        <= 8'h00;
            preamble_valid <= 1'b0;
            sync_found     <= 1'b0;
            rx_byte_valid  <= 1'b0;
            rx_byte        <= 8'h00;
            crc_clr_q      <= 1'b0;
            crc_en_q       <= 1'b0;
            crc_byte_q     <= 8'h00;
        end else begin
            rx_byte_valid <= 1'b0;
            crc_clr_q     <= 1'b0;
            crc_en_q      <= 1'b0;
            if (!ctrl_q[`RPQ_CTRL_EN]) begin
                state_q        <= ST_SEARCH;
                run_q          <= 7'h00;
                phase_q        <= 3'd0;
                preamble_valid <= 1'b0;
                sync_found     <= 1'b0;
            end else if (rx_bit_valid) begin
                shift_q <= shift_n;
                last_q  <= bit_in;
                case (state_q)
                    ST_SEARCH: begin
                        run_q   <= run_n;                                       // RQ17
                        phase_q <= alt_ok ? phase_q + 3'd1 : 3'd0;              // RQ8
                        if (skip) begin
                            state_q <= ST_SYNC;                                 // RQ9 RQ7
                        end else if (alt_ok && run_n >= thr) begin
                            preamble_valid <= 1'b1;                             // RQ1
                            state_q <= ST_SYNC;                                 // RQ3
                        end
                    end
                    ST_SYNC: begin
                        if (sync_hit) begin
                            sync_found <= 1'b1;                                 // RQ3
                            state_q   <= ST_DATA;
                            bitn_q    <= 3'd0;
                            bytes_q   <= 8'h00;
                            crc_clr_q <= 1'b1;
                        end
                    end
                    ST_DATA, ST_CRC: begin
                        bitn_q <= bitn_q + 3'd1;
                        if (bitn_q == 3'd7) begin
                            crc_en_q   <= 1'b1;                                 // RQ10
                            crc_byte_q <= shift_n[7:0];
                            bytes_q    <= bytes_q + 8'h01;
                            if (state_q == ST_DATA) begin
                                rx_byte       <= shift_n[7:0];
                                rx_byte_valid <= 1'b1;
                                if (bytes_q + 8'h01 == plen_q) begin
                                    state_q <= ST_CRC;
                                    bytes_q <= 8'h00;
                                end
                            end else if (bytes_q == 8'h01) begin
                                state_q <= ST_SEARCH;
                            end
                        end
                    end
                    default: state_q <= ST_SEARCH;
                endcase
            end
            // verdict one cycle after the last checksum byte has been summed
            if (!crc_en_q && state_q == ST_SEARCH && sync_found) begin
                sync_found     <= 1'b0;
                preamble_valid <= 1'b0;
                run_q          <= 7'h00;
                phase_q        <= 3'd0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gain settle watch: done at the next bit strobe or after the time bound
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            agc_busy_q <= 1'b0;
            agc_cnt_q  <= 9'h000;
        end else if (agc_step) begin
            agc_busy_q <= 1'b1;
            agc_cnt_q  <= 9'h000;
        end else if (agc_busy_q) begin
            agc_cnt_q <= agc_cnt_q + 9'h001;
            if (rx_bit_valid || agc_cnt_q == AGC_CYC[8:0] - 9'h001)
                agc_busy_q <= 1'b0;                                             // RQ12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // correction range 0.25 or 0.35 of filter width; 45/128 stands in, avoiding a divider
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            afc_lim_q  <= 20'h00000;
            afc_corr_q <= 20'h00000;
            rssi_q     <= 8'h00;
        end else begin
            rssi_q    <= rssi_raw;                                              // RQ11
            afc_lim_q <= ctrl_q[`RPQ_CTRL_AFC] ? {1'b0, afc_prod[25:7]}
                                               : {2'b00, filt_q[19:2]};         // RQ13
            afc_corr_q <= (abs_err > afc_lim_q) ? afc_lim_q : abs_err;          // RQ13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status: set wins over the read that clears it
    wire rx_done = !crc_en_q && state_q == ST_SEARCH && sync_found;
    wire agc_ev  = agc_busy_q && (rx_bit_valid || agc_cnt_q == AGC_CYC[8:0] - 9'h001) && !agc_step;
    wire [`RPQ_EV_W-1:0] ev_now = {agc_ev,
                                   rx_done & (rx_crc != 16'h0000),
                                   rx_done & (rx_crc == 16'h0000),              // RQ10
                                   ctrl_q[`RPQ_CTRL_EN] & rx_bit_valid & state_q == ST_SYNC
                                       & sync_hit,
                                   ctrl_q[`RPQ_CTRL_EN] & rx_bit_valid & state_q == ST_SEARCH
                                       & ~skip & alt_ok & (run_n >= thr)};
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stat_q <= {`RPQ_EV_W{1'b0}};
            irq    <= 1'b0;
        end else begin
            stat_q <= ((rd_acc && paddr == `RPQ_ADDR_STAT) ? {`RPQ_EV_W{1'b0}} : stat_q)
                      | ev_now;
            irq    <= |(stat_q & mask_q);
        end
    end

    rpq_crc16 u_rx_crc (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clr      (crc_clr_q),
        .en       (crc_en_q),
        .din      (crc_byte_q),
        .crc      (rx_crc)
    );

    rpq_crc16 u_tx_crc (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clr      (wr_acc && paddr == `RPQ_ADDR_CTRL && pwdata[`RPQ_CTRL_TXCLR]),
        .en       (tx_en_q),
        .din      (tx_byte_q),
        .crc      (tx_crc)
    );

endmodule // rpq_top

// File: sim/rpq_top_asserts.sv
// checker on the qualifier top ports: apb handshake and receive event order
// assumes a bind to rpq_top, one clock domain, reset active low
`timescale 1ns/1ps
module rpq_top_asserts (
    input wire logic core_clk,       // clock
    input wire logic resetn,         // async reset, active low
    input wire logic psel,           // apb select
    input wire logic penable,        // apb access phase
    input wire logic pready,         // apb ready
    input wire logic pslverr,        // apb error
    input wire logic rx_bit_valid,   // bit strobe
    input wire logic preamble_valid, // lead-in qualified
    input wire logic sync_found,     // sync seen
    input wire logic rx_byte_valid   // payload byte pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // events only ever follow a bit strobe by one cycle
    a_pre_after_bit: assert property ($rose(preamble_valid) |-> $past(rx_bit_valid))
        else $error("lead-in flag without a bit strobe");
    a_sync_after_bit: assert property ($rose(sync_found) |-> $past(rx_bit_valid))
        else $error("sync flag without a bit strobe");
    a_byte_after_bit: assert property (rx_byte_valid |-> $past(rx_bit_valid))
        else $error("byte pulse without a bit strobe");
    a_byte_needs_sync: assert property (rx_byte_valid |-> sync_found)
        else $error("payload byte before sync");
    a_byte_one_cycle: assert property (rx_byte_valid |=> !rx_byte_valid)
        else $error("byte pulse too long");
    // apb slave answers after exactly one wait cycle
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside completion");
    c_pre: cover property ($rose(preamble_valid));
    c_sync: cover property ($rose(sync_found));
    c_err: cover property (pslverr);
endmodule // rpq_top_asserts
bind rpq_top rpq_top_asserts u_rpq_top_asserts (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(rx_bit_valid), .preamble_valid(preamble_valid),
    .sync_found(sync_found), .rx_byte_valid(rx_byte_valid));

// File: sim/rpq_tx_model.sv
// remote transmitter: sends bits msb first, one strobe every four cycles
// assumes the caller sizes the lead-in, including margin for timing and afc
`timescale 1ns/1ps
module rpq_tx_model (
    input  wire logic core_clk,     // bit strobes launched on this clock
    output logic      rx_bit,       // demodulated bit
    output logic      rx_bit_valid  // one pulse per bit
);
    initial begin
        rx_bit = 1'b0;
        rx_bit_valid = 1'b0;
    end
    // caller sends threshold plus settling bits
    task automatic send(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk);
            rx_bit <= v[i];
            rx_bit_valid <= 1'b1;
            @(posedge core_clk);
            rx_bit_valid <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
        rx_bit <= ~v[0]; // stale line must not look like the last bit
    endtask
endmodule // rpq_tx_model

// File: sim/rpq_top_tb.sv
// self-checking bench of rpq_top: registers, lead-in, sync, checksum, gain
// assumes rpq_tx_model as the far side and the design constants header
`timescale 1ns/1ps
`include "rpq_consts.vh"
module rpq_top_tb;
    logic        core_clk, resetn, psel, penable, pwrite, agc_step, er;
    logic        pready, pslverr, irq, preamble_valid, sync_found, rx_byte_valid;
    logic        rx_bit, rx_bit_valid;
    logic [7:0]  paddr, rssi_raw, rx_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] crc_a5;
    int          err_count, samples_checked, nbytes = 0;
    logic signed [19:0] freq_err = 20'sh80000;
    rpq_top #(.AGC_CYC(8)) u_rpq_top (.core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
        .rssi_raw(rssi_raw), .agc_step(agc_step), .freq_err(freq_err), .irq(irq),
        .preamble_valid(preamble_valid), .sync_found(sync_found),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));
    rpq_tx_model u_rpq_tx_model (.core_clk(core_clk), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid));
    // payload byte pulses, judged once a packet is over
    always @(posedge core_clk) if (rx_byte_valid) nbytes <= nbytes + 1;
    ////////////////////////////////////////
    // 125 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; waits on pready, the watchdog bounds a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // bitwise ccitt step, msb first
    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0);
        return c;
    endfunction
    task automatic final_report;
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_regs;
        rdchk(`RPQ_ADDR_CTRL, 32'h11);
        rdchk(`RPQ_ADDR_THRESH, 32'h14);
        apb(1'b1, `RPQ_ADDR_THRESH, 32'hff);
        rdchk(`RPQ_ADDR_THRESH, 32'h7f);
        apb(1'b1, `RPQ_ADDR_THRESH, 32'h14);
        rdchk(8'h3c, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, `RPQ_ADDR_RATE, 32'h32);
        rdchk(`RPQ_ADDR_RATE, 32'h64);
        apb(1'b1, `RPQ_ADDR_FILT, 32'hfffff);
        rdchk(`RPQ_ADDR_FILT, 32'hcf850);
        rdchk(`RPQ_ADDR_AFC, 32'h3e143e14);
        apb(1'b0, `RPQ_ADDR_STATE, 32'h0);
        chk({24'h0, rd[31:24]}, 32'h5a);
        apb(1'b1, `RPQ_ADDR_CTRL, 32'h31);
        apb(1'b1, `RPQ_ADDR_TXCRC, 32'ha5);
        rdchk(`RPQ_ADDR_TXCRC, {16'h0, crc_a5});
        apb(1'b1, `RPQ_ADDR_MASK, 32'h1f);
        apb(1'b1, `RPQ_ADDR_PLEN, 32'h1);
    endtask
    // a repeated bit restarts the run, so 19 more bits fall one short
    task automatic t_std;
        u_rpq_tx_model.send(64'h2aa, 10);
        u_rpq_tx_model.send(64'h0, 1);
        u_rpq_tx_model.send(64'h55555, 19);
        chk({31'h0, preamble_valid}, 32'h0);
        u_rpq_tx_model.send(64'h0, 1);
        chk({31'h0, preamble_valid}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, sync_found}, 32'h0);
        u_rpq_tx_model.send(64'h2dd4aa, 24);
        chk({31'h0, sync_found}, 32'h1);
        u_rpq_tx_model.send({40'h0, 8'ha5, crc_a5}, 24);
        chk({24'h0, rx_byte}, 32'ha5);
        chk(nbytes, 32'h1);
        rdchk(`RPQ_ADDR_STAT, 32'h07);
        repeat (2) @(posedge core_clk);
        chk({30'h0, irq, preamble_valid}, 32'h0);
    endtask
    // sync only, with a corrupted checksum
    task automatic t_synco;
        apb(1'b1, `RPQ_ADDR_CTRL, 32'h15);
        u_rpq_tx_model.send(64'h2dd4aa, 24);
        chk({30'h0, sync_found, preamble_valid}, 32'h2);
        u_rpq_tx_model.send({40'h0, 8'ha5, crc_a5 ^ 16'h1}, 24);
        rdchk(`RPQ_ADDR_STAT, 32'h0a);
    endtask
    // masked gain event, no bits arriving
    task automatic t_agc;
        apb(1'b1, `RPQ_ADDR_MASK, 32'h0);
        agc_step <= 1'b1;
        @(posedge core_clk);
        agc_step <= 1'b0;
        repeat (12) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(`RPQ_ADDR_STAT, 32'h10);
    endtask
    // custom pattern mode also takes the alternating lead-in
    task automatic t_custom;
        apb(1'b1, `RPQ_ADDR_CTRL, 32'h13);
        u_rpq_tx_model.send(64'h2aaaa, 18);
        chk({31'h0, preamble_valid}, 32'h1);
        apb(1'b1, `RPQ_ADDR_CTRL, 32'h0);
        @(posedge core_clk);
        chk({31'h0, preamble_valid}, 32'h0);
        rdchk(`RPQ_ADDR_STAT, 32'h01);
    endtask
    // main sequence
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        agc_step = 1'b0;
        rssi_raw = 8'h5a;
        err_count = 0;
        samples_checked = 0;
        crc_a5 = crc8(16'hffff, 8'ha5);
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs;
        t_std;
        t_synco;
        t_agc;
        t_custom;
        final_report;
    end
    // watchdog, well beyond the roughly 700 cycles needed
    initial begin
        #100000;
        err_count++;
        final_report;
    end
endmodule // rpq_top_tb
